// *** design/dsp_debug_port.sv ***
// Debug serial port: shift register, trap enables, freeze and debug entry/exit
//
// Contract
// R1: Debug software never sets the external interrupt enable while in debug mode.
// R2: In debug mode an enabled external interrupt level is reported every clock.
// R3: Saved PC and state update only on debug entry, never on later exceptions.
// R4: Return from interrupt in debug mode leaves it and drops freeze.
// R5: Pending enabled cause after return re-enters debug mode at once.
// R6: Each serial clock edge shifts; new top bit goes onto serial out. Code shifts on the serial clock rise, or every system clock when self clocked.
// R7: Ready and start bits, not clock gating, decide when data shifts.
// R8: Serial clock level at reset decides immediate debug entry.
// R9: Serial in level at reset selects configuration and port clocking mode.
// R10: Serial out changes only on the selected shift clock.
// R11: Freeze output asserted, on the system clock, while in debug mode.
// R12: While frozen the fetch flush status shows binary 11.
// R13: Freeze status is a bit of the shifted-out data.
// R14: Instruction, data and trap registers built as shift plus trap registers.
// R15: Shift register is 35 bits, loaded serially on the selected clock.
// R16: Every debug mode fetch reads the instruction port, shifted in first.
// R17: Data port read returns shifted data; write loads shift register outward.
// R18: Trap register is 9 bits: six enables, two breakpoints, one sync.
// R19: Core cannot access trap register; only trap transmissions load it.
// R20: Trap enables readable through the two watch control registers.
// R21: Shift register selected by port address with special register attribute.
// R22: Mismatch of received item against core expectation reports sequencing error.
// R23: Serial in latched eight clocks after soft reset; high means self clocked.
// R24: Start bit scan begins 16 clocks after reset, after serial in low.
// R25: Mode bit set means 10-bit transmission of seven bits into trap register.
// R26: Reading the cause register clears all its bits.
module dsp_debug_port
   import dsp_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Development tool pins
   input wire logic debugSerialClock,
   input wire logic debugSerialIn,
   input wire logic softResetIn,
   output logic debugSerialOut,
   output logic freezeOut,
   output logic [1:0] fetchFlushStatus,
   output logic configModeStrap,
   // Core events
   input wire logic debugModeEn,
   input wire logic [WORD_W-1:0] causeSetIn,
   input wire logic extIrqLevel,
   input wire logic externalIrqEnable,
   input wire logic rfiExec,
   input wire logic [WORD_W-1:0] corePc,
   input wire logic [WORD_W-1:0] coreState,
   output logic [WORD_W-1:0] saveRestorePc,
   output logic [WORD_W-1:0] saveRestoreState,
   output logic debugExceptionPulse,
   // Internal special register bus
   input wire logic [9:0] busAddr,
   input wire logic busSprAttr,
   input wire logic busFetch,
   input wire logic busRead,
   input wire logic busWrite,
   input wire logic [WORD_W-1:0] busWdata,
   output logic busAck,
   output logic [WORD_W-1:0] busRdata,
   // Trap enable control outputs
   output logic [TRAP_W-1:0] trapEnableCtrl
);
   logic dsckSync;
   logic dinSync;
   logic srSync;
   logic [SHIFT_W-1:0] shiftQ;
   logic shiftLoad;
   logic shiftEn;
   logic [SHIFT_W-1:0] shiftLoadData;

   dsp_sync #(.WIDTH(3)) u_sync (
      .clk(clk),
      .reset_n(reset_n),
      .asyncIn({debugSerialClock, debugSerialIn, softResetIn}),
      .syncOut({dsckSync, dinSync, srSync})
   );

   dsp_shifter #(.WIDTH(SHIFT_W)) u_shift ( // R14 R15
      .clk(clk),
      .reset_n(reset_n),
      .loadEn(shiftLoad),
      .loadData(shiftLoadData),
      .shiftEn(shiftEn),
      .serialIn(dinSync),
      .q(shiftQ)
   );

   dsp_port_e state_ff, nxt_state;
   logic [4:0] rstCnt_ff, nxt_rstCnt;
   logic selfClock_ff, nxt_selfClock;
   logic strap_ff, nxt_strap;
   logic dsckPrev_ff, nxt_dsckPrev;
   logic [5:0] bitCnt_ff, nxt_bitCnt;
   logic trapMode_ff, nxt_trapMode;
   logic done_ff, nxt_done;
   logic rxValid_ff, nxt_rxValid;
   logic rxIsData_ff, nxt_rxIsData;
   logic [WORD_W-1:0] rxWord_ff, nxt_rxWord;
   logic [1:0] outStatus_ff, nxt_outStatus;
   logic [WORD_W-1:0] outData_ff, nxt_outData;
   logic [TRAP_W-1:0] trap_ff, nxt_trap;
   logic [WORD_W-1:0] cause_ff, nxt_cause;
   logic [WORD_W-1:0] enable_ff, nxt_enable;
   logic frozen_ff, nxt_frozen;
   logic [WORD_W-1:0] pcSave_ff, nxt_pcSave;
   logic [WORD_W-1:0] stSave_ff, nxt_stSave;
   logic excPulse_ff, nxt_excPulse;
   logic ack_ff, nxt_ack;
   logic [WORD_W-1:0] rdata_ff, nxt_rdata;
   logic debug_serial_out_ff, nxt_debug_serial_out;
   logic [1:0] flush_ff, nxt_flush;

   logic tick;
   logic portSel;
   logic [5:0] txLen;
   logic [WORD_W-1:0] extSet;
   logic [WORD_W-1:0] statusWord;

   // Self clocked mode shifts every system clock; otherwise on serial clock rise
   assign tick = selfClock_ff | (dsckSync & ~dsckPrev_ff); // R6 R10
   assign portSel = busSprAttr & ((busAddr == SPR_INSTR_PORT) | (busAddr == SPR_DATA_PORT)); // R21
   assign txLen = trapMode_ff ? TRAP_LEN : DEBUG_LEN; // R25
   assign extSet = (frozen_ff & extIrqLevel & externalIrqEnable) ? (WORD_W'(1) << CAUSE_EXT_BIT) : '0; // R1 R2
   // Non-data answers carry freeze status in bit 31 and an idle download flag
   assign statusWord = (outStatus_ff == ST_VALID) ? outData_ff
                       : {frozen_ff, 1'b1, {(WORD_W-2){1'b1}}}; // R13
   assign shiftLoadData = {outStatus_ff, statusWord, 1'b1};
   assign shiftLoad = (state_ff == PS_IDLE) & tick & dinSync & ~rxValid_ff;
   assign shiftEn = (state_ff == PS_SHIFT) & tick & (bitCnt_ff < txLen);

   always_comb begin
      nxt_state = state_ff;
      nxt_rstCnt = rstCnt_ff;
      nxt_selfClock = selfClock_ff;
      nxt_strap = strap_ff;
      nxt_dsckPrev = dsckSync;
      nxt_bitCnt = bitCnt_ff;
      nxt_trapMode = trapMode_ff;
      nxt_done = 1'b0;
      nxt_rxValid = rxValid_ff;
      nxt_rxIsData = rxIsData_ff;
      nxt_rxWord = rxWord_ff;
      nxt_outStatus = outStatus_ff;
      nxt_outData = outData_ff;
      nxt_trap = trap_ff;
      nxt_cause = cause_ff;
      nxt_enable = enable_ff;
      nxt_frozen = frozen_ff;
      nxt_pcSave = pcSave_ff;
      nxt_stSave = stSave_ff;
      nxt_excPulse = 1'b0;
      nxt_ack = 1'b0;
      nxt_rdata = rdata_ff;
      nxt_debug_serial_out = debug_serial_out_ff;
      nxt_flush = frozen_ff ? FLUSH_FROZEN : FLUSH_RUN; // R12

      // Reset sequencing and straps
      if (srSync) begin
         nxt_state = PS_RESET;
         nxt_rstCnt = '0;
      end else begin
         unique case (state_ff)
            PS_RESET: begin
               nxt_rstCnt = rstCnt_ff + 5'h01;
               if (nxt_rstCnt == STRAP_CLKS) begin
                  nxt_selfClock = dinSync; // R9 R23
                  nxt_strap = dinSync; // R9
                  if (dsckSync) begin
                     nxt_cause[CAUSE_RESET_BIT] = 1'b1; // R8
                  end
               end
               if (nxt_rstCnt == SCAN_CLKS) begin
                  nxt_state = dinSync ? PS_WAIT_LOW : PS_IDLE; // R24
               end
            end
            PS_WAIT_LOW: begin
               if (!dinSync) begin
                  nxt_state = PS_IDLE; // R24
               end
            end
            PS_IDLE: begin
               // Ready is shown low only when a new item can be taken
               if (tick) begin
                  nxt_debug_serial_out = rxValid_ff; // R7
               end
               if (shiftLoad) begin
                  nxt_state = PS_SHIFT; // R7
                  nxt_bitCnt = 6'h01;
                  nxt_debug_serial_out = outStatus_ff[1]; // R6
               end
            end
            PS_SHIFT: begin
               if (shiftEn) begin
                  nxt_bitCnt = bitCnt_ff + 6'h01;
                  nxt_debug_serial_out = shiftQ[SHIFT_W-2]; // R6 R10
                  if (bitCnt_ff == 6'h01) begin
                     nxt_trapMode = dinSync; // R25
                  end
                  if (nxt_bitCnt == txLen) begin
                     nxt_done = 1'b1;
                     nxt_state = PS_IDLE;
                  end
               end
            end
         endcase
      end

      // Completed transmission
      if (done_ff) begin
         if (trapMode_ff) begin
            if (!shiftQ[TRAP_DATA_W]) begin
               nxt_trap[TRAP_W-1:TRAP_SYNC_BIT] = shiftQ[TRAP_DATA_W-1:0]; // R18 R19 R25
            end else if (shiftQ[4:0] == CMD_BREAK) begin
               nxt_trap[TRAP_BPM_BIT] = shiftQ[5]; // R18 R19
               nxt_trap[TRAP_BPN_BIT] = shiftQ[6];
            end
         end else begin
            nxt_rxValid = 1'b1;
            nxt_rxIsData = shiftQ[WORD_W];
            nxt_rxWord = shiftQ[WORD_W-1:0];
            if (outStatus_ff == ST_VALID) begin
               nxt_outStatus = ST_NULL;
            end
         end
      end

      // Cause register: hardware sets win over the read clear
      if (busRead & busSprAttr & (busAddr == SPR_CAUSE) & ~ack_ff) begin
         nxt_cause = '0; // R26
      end
      nxt_cause = nxt_cause | causeSetIn | extSet; // R2
      if (frozen_ff & ((|causeSetIn) | (|extSet))) begin
         nxt_excPulse = 1'b1; // R2
         nxt_outStatus = ST_CORE_INT;
      end

      // Debug mode entry and exit
      if (frozen_ff) begin
         if (rfiExec) begin
            nxt_frozen = 1'b0; // R4
         end
      end else if (debugModeEn & (|(cause_ff & enable_ff))) begin
         nxt_frozen = 1'b1; // R5 R11
         nxt_pcSave = corePc; // R3
         nxt_stSave = coreState; // R3
      end

      // Internal bus; requests are held by the core until acknowledged
      if (!ack_ff) begin
         if (busFetch & frozen_ff & rxValid_ff) begin // R16
            nxt_rxValid = 1'b0;
            if (rxIsData_ff) begin
               nxt_outStatus = ST_SEQ_ERR; // R22
            end else begin
               nxt_ack = 1'b1;
               nxt_rdata = rxWord_ff;
            end
         end else if (portSel & busRead & (busAddr == SPR_DATA_PORT) & rxValid_ff) begin
            nxt_rxValid = 1'b0;
            if (!rxIsData_ff) begin
               nxt_outStatus = ST_SEQ_ERR; // R22
            end else begin
               nxt_ack = 1'b1;
               nxt_rdata = rxWord_ff; // R17
            end
         end else if (portSel & busWrite & (busAddr == SPR_DATA_PORT)) begin
            nxt_ack = 1'b1;
            nxt_outData = busWdata; // R17
            nxt_outStatus = ST_VALID;
         end else if (busSprAttr & busRead & ~portSel) begin
            nxt_ack = 1'b1;
            unique case (busAddr)
               SPR_CAUSE: nxt_rdata = cause_ff;
               SPR_ENABLE: nxt_rdata = enable_ff;
               SPR_INSTR_WATCH: nxt_rdata = {28'h0000000, trap_ff[8:5]}; // R20
               SPR_LS_WATCH2: nxt_rdata = {30'h0, trap_ff[4:3]}; // R20
               default: nxt_rdata = '0;
            endcase
         end else if (busSprAttr & busWrite & (busAddr == SPR_ENABLE)) begin
            nxt_ack = 1'b1;
            nxt_enable = busWdata;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= PS_RESET;
         rstCnt_ff <= '0;
         selfClock_ff <= 1'b0;
         strap_ff <= 1'b0;
         dsckPrev_ff <= 1'b0;
         bitCnt_ff <= '0;
         trapMode_ff <= 1'b0;
         done_ff <= 1'b0;
         rxValid_ff <= 1'b0;
         rxIsData_ff <= 1'b0;
         rxWord_ff <= '0;
         outStatus_ff <= ST_NULL;
         outData_ff <= '0;
         trap_ff <= TRAP_RESET;
         cause_ff <= '0;
         enable_ff <= ENABLE_RESET;
         frozen_ff <= 1'b0;
         pcSave_ff <= '0;
         stSave_ff <= '0;
         excPulse_ff <= 1'b0;
         ack_ff <= 1'b0;
         rdata_ff <= '0;
         debug_serial_out_ff <= 1'b1;
         flush_ff <= FLUSH_RUN;
      end else begin
         state_ff <= nxt_state;
         rstCnt_ff <= nxt_rstCnt;
         selfClock_ff <= nxt_selfClock;
         strap_ff <= nxt_strap;
         dsckPrev_ff <= nxt_dsckPrev;
         bitCnt_ff <= nxt_bitCnt;
         trapMode_ff <= nxt_trapMode;
         done_ff <= nxt_done;
         rxValid_ff <= nxt_rxValid;
         rxIsData_ff <= nxt_rxIsData;
         rxWord_ff <= nxt_rxWord;
         outStatus_ff <= nxt_outStatus;
         outData_ff <= nxt_outData;
         trap_ff <= nxt_trap;
         cause_ff <= nxt_cause;
         enable_ff <= nxt_enable;
         frozen_ff <= nxt_frozen;
         pcSave_ff <= nxt_pcSave;
         stSave_ff <= nxt_stSave;
         excPulse_ff <= nxt_excPulse;
         ack_ff <= nxt_ack;
         rdata_ff <= nxt_rdata;
         debug_serial_out_ff <= nxt_debug_serial_out;
         flush_ff <= nxt_flush;
      end
   end

   assign debugSerialOut = debug_serial_out_ff;
   assign freezeOut = frozen_ff; // R11
   assign fetchFlushStatus = flush_ff;
   assign configModeStrap = strap_ff;
   assign saveRestorePc = pcSave_ff;
   assign saveRestoreState = stSave_ff;
   assign debugExceptionPulse = excPulse_ff;
   assign busAck = ack_ff;
   assign busRdata = rdata_ff;
   assign trapEnableCtrl = trap_ff;
endmodule

// *** design/dsp_pkg.sv ***
// Constants and types shared by the debug serial port design
package dsp_pkg;
   localparam int SHIFT_W = 35;
   localparam int WORD_W = 32;
   localparam int TRAP_W = 9;
   localparam int TRAP_DATA_W = 7;
   localparam logic [5:0] TRAP_LEN = 6'h0A;
   localparam logic [5:0] DEBUG_LEN = 6'h23;
   localparam logic [4:0] STRAP_CLKS = 5'h08;
   localparam logic [4:0] SCAN_CLKS = 5'h10;
   localparam logic [1:0] FLUSH_FROZEN = 2'h3;
   localparam logic [1:0] FLUSH_RUN = 2'h0;
   // Outgoing status codes
   localparam logic [1:0] ST_VALID = 2'h0;
   localparam logic [1:0] ST_SEQ_ERR = 2'h1;
   localparam logic [1:0] ST_CORE_INT = 2'h2;
   localparam logic [1:0] ST_NULL = 2'h3;
   // Special register addresses on the internal bus
   localparam logic [9:0] SPR_INSTR_PORT = 10'h276;
   localparam logic [9:0] SPR_DATA_PORT = 10'h277;
   localparam logic [9:0] SPR_CAUSE = 10'h094;
   localparam logic [9:0] SPR_ENABLE = 10'h095;
   localparam logic [9:0] SPR_INSTR_WATCH = 10'h09E;
   localparam logic [9:0] SPR_LS_WATCH2 = 10'h099;
   // Cause bit positions and reset values
   localparam int CAUSE_RESET_BIT = 31;
   localparam int CAUSE_EXT_BIT = 7;
   localparam logic [31:0] ENABLE_RESET = 32'hFFFFFFFF;
   localparam logic [8:0] TRAP_RESET = 9'h000;
   // Trap enable control layout: [8:3] enables, [2] sync, [1] maskable bp, [0] nonmaskable bp
   localparam int TRAP_SYNC_BIT = 2;
   localparam int TRAP_BPM_BIT = 1;
   localparam int TRAP_BPN_BIT = 0;
   localparam logic [4:0] CMD_BREAK = 5'h1F;
   typedef enum logic [1:0] {PS_RESET, PS_WAIT_LOW, PS_IDLE, PS_SHIFT} dsp_port_e;
endpackage

// *** design/dsp_shifter.sv ***
// Port shift register: serial shift in at the bottom, parallel load
module dsp_shifter #(
   parameter int WIDTH = 35
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Control
   input wire logic loadEn,
   input wire logic [WIDTH-1:0] loadData,
   input wire logic shiftEn,
   input wire logic serialIn,
   // Contents
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] shift_ff;
   logic [WIDTH-1:0] nxt_shift;

   initial begin
      if (WIDTH < 2) $error("dsp_shifter width must be at least 2");
   end

   always_comb begin
      nxt_shift = shift_ff;
      if (loadEn) begin
         nxt_shift = loadData;
      end else if (shiftEn) begin
         nxt_shift = {shift_ff[WIDTH-2:0], serialIn};
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         shift_ff <= '0;
      end else begin
         shift_ff <= nxt_shift;
      end
   end

   assign q = shift_ff;
endmodule

// *** design/dsp_sync.sv ***
// Two flip-flop synchroniser for pin inputs
module dsp_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Data
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] stage1_ff;
   logic [WIDTH-1:0] stage2_ff;

   initial begin
      if (WIDTH < 1) $error("dsp_sync width must be positive");
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stage1_ff <= '0;
         stage2_ff <= '0;
      end else begin
         stage1_ff <= asyncIn;
         stage2_ff <= stage1_ff;
      end
   end

   assign syncOut = stage2_ff;
endmodule

// *** dv/dsp_debug_port_sva.sv ***
// Assertion checker for the debug serial port
module dsp_debug_port_sva
   import dsp_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Pins
   input wire logic debugSerialClock,
   input wire logic freezeOut,
   input wire logic [1:0] fetchFlushStatus,
   input wire logic configModeStrap,
   // Core side
   input wire logic debugModeEn,
   input wire logic extIrqLevel,
   input wire logic externalIrqEnable,
   input wire logic rfiExec,
   input wire logic [WORD_W-1:0] saveRestorePc,
   input wire logic debugExceptionPulse,
   input wire logic busFetch,
   input wire logic busAck,
   input wire logic [TRAP_W-1:0] trapEnableCtrl
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   logic [4:0] sinceHigh_ff;
   logic [4:0] nxt_sinceHigh;
   // Cycles since the serial clock pin was high, saturating
   always_comb begin
      nxt_sinceHigh = sinceHigh_ff;
      if (debugSerialClock) nxt_sinceHigh = 5'h00;
      else if (sinceHigh_ff != 5'h1F) nxt_sinceHigh = sinceHigh_ff + 5'h01;
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) sinceHigh_ff <= 5'h1F;
      else sinceHigh_ff <= nxt_sinceHigh;
   end
   AST_FLUSH_TRACK: assert property (fetchFlushStatus == ($past(freezeOut) ? FLUSH_FROZEN : FLUSH_RUN))
      else $error("flush status not following freeze");
   AST_TRAP_SERIAL: assert property ($changed(trapEnableCtrl) |-> configModeStrap || sinceHigh_ff < 5'h0C)
      else $error("trap register changed without a serial frame");
   AST_FETCH_FROZEN: assert property (busAck && $past(busFetch) |-> $past(freezeOut))
      else $error("fetch answered outside debug mode");
   AST_ACK_PULSE: assert property (busAck |=> !busAck)
      else $error("bus ack longer than one cycle");
   AST_FREEZE_FALL: assert property ($fell(freezeOut) |-> $past(rfiExec) || $past(rfiExec, 2))
      else $error("freeze dropped without return");
   AST_RFI_EXIT: assert property (rfiExec && freezeOut |-> ##[1:2] !freezeOut)
      else $error("return did not leave debug mode");
   AST_IRQ_LEVEL: assert property ((freezeOut && extIrqLevel && externalIrqEnable) [*3] |-> debugExceptionPulse)
      else $error("enabled level not reported each cycle");
   AST_SAVE_HELD: assert property (freezeOut && $past(freezeOut) && $past(freezeOut, 2) |-> $stable(saveRestorePc))
      else $error("saved pc changed inside debug mode");
   AST_ENTRY_ENABLED: assert property ($rose(freezeOut) |-> $past(debugModeEn))
      else $error("freeze without debug mode enabled");
endmodule

bind dsp_debug_port dsp_debug_port_sva i_dsp_debug_port_sva (.clk, .reset_n, .debugSerialClock, .freezeOut,
   .fetchFlushStatus, .configModeStrap, .debugModeEn, .extIrqLevel, .externalIrqEnable, .rfiExec, .saveRestorePc,
   .debugExceptionPulse, .busFetch, .busAck, .trapEnableCtrl);

// *** dv/dsp_tool_model.sv ***
// Behavioural development tool on the serial link
module dsp_tool_model
(
   // Link pins
   output logic debugSerialClock,
   output logic debugSerialIn,
   input wire logic debugSerialOut
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      debugSerialClock = 1'b0;
      debugSerialIn = 1'b0;
   end
   // Levels held across reset act as straps
   task automatic pins(input logic c, d);
      debugSerialClock = c;
      debugSerialIn = d;
   endtask
   // Clock runs while waiting: unless self clocked, ready only moves on a serial clock edge
   task automatic xfer(input logic m, c, input logic [31:0] d, input int n, output logic [33:0] got,
      output bit ok);
      logic [34:0] b;
      int k;
      ok = 1'b0;
      got = '0;
      for (k = 0; k < 400 && !ok; k++) begin
         debugSerialIn = 1'b0;
         #30;
         debugSerialClock = 1'b1;
         #62.5;
         debugSerialClock = 1'b0;
         #32.5;
         ok = (debugSerialOut === 1'b0);
      end
      b = {1'b1, m, c, d << (32 - n)};
      for (k = 0; k < n + 3 && ok; k++) begin
         debugSerialIn = b[34-k];
         #30;
         debugSerialClock = 1'b1;
         #62.5;
         debugSerialClock = 1'b0;
         #32.5;
         if (k < 34) got[33-k] = debugSerialOut;
      end
      // Released data line must not look like a held value
      debugSerialIn = ~debugSerialIn;
   endtask
endmodule

// *** dv/tb_top.sv ***
// Self-checking bench for the debug serial port
module tb_top
   import dsp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, reset_n, softResetIn, debugModeEn, extIrqLevel, externalIrqEnable, rfiExec;
   logic busSprAttr, busFetch, busRead, busWrite, ack;
   logic [WORD_W-1:0] causeSetIn, corePc, coreState, busWdata, saveRestorePc, saveRestoreState, busRdata;
   logic [9:0] busAddr;
   logic [1:0] fetchFlushStatus;
   logic [TRAP_W-1:0] trapEnableCtrl, te;
   logic [33:0] got;
   wire logic debugSerialClock, debugSerialIn;
   logic debugSerialOut, freezeOut, configModeStrap, debugExceptionPulse, busAck;
   int err_total, compares, n;

   dsp_debug_port i_dsp_debug_port (.clk, .reset_n, .debugSerialClock, .debugSerialIn, .softResetIn, .debugSerialOut,
      .freezeOut, .fetchFlushStatus, .configModeStrap, .debugModeEn, .causeSetIn, .extIrqLevel, .externalIrqEnable,
      .rfiExec, .corePc, .coreState, .saveRestorePc, .saveRestoreState, .debugExceptionPulse, .busAddr, .busSprAttr,
      .busFetch, .busRead, .busWrite, .busWdata, .busAck, .busRdata, .trapEnableCtrl);
   dsp_tool_model i_dsp_tool_model (.debugSerialClock, .debugSerialIn, .debugSerialOut);

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic print_verdict();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [33:0] e, g);
      compares++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   // Request held until ack seen, dropped before the next edge
   task automatic bus(input logic f, r, w, input logic [9:0] a, input logic [31:0] d, input int lim);
      int k;
      @(negedge clk);
      {busFetch, busRead, busWrite, busSprAttr} = {f, r, w, ~f};
      busAddr = a;
      busWdata = d;
      ack = 1'b0;
      for (k = 0; k < lim && ack !== 1'b1; k++) begin
         @(negedge clk);
         ack = busAck;
      end
      {busFetch, busRead, busWrite, busSprAttr} = 4'h0;
   endtask
   task automatic rd(input logic [9:0] a);
      bus(1'b0, 1'b1, 1'b0, a, 32'h0, 20);
      chk("read ack", 34'h1, ack);
   endtask
   task automatic fetch(input logic [31:0] e);
      bus(1'b1, 1'b0, 1'b0, SPR_INSTR_PORT, 32'h0, 40);
      chk("fetch", {2'h2, e}, {ack, 1'b0, busRdata});
   endtask
   task automatic frame(input logic m, c, input logic [31:0] d, input int len);
      bit ok;
      i_dsp_tool_model.xfer(m, c, d, len, got, ok);
      if (!ok) begin
         err_total++;
         $display("BAD ready exp 0 got timeout");
         print_verdict();
      end
   endtask
   task automatic pulse(input int b);
      @(negedge clk);
      causeSetIn[b] = 1'b1;
      @(negedge clk);
      causeSetIn = '0;
   endtask
   task automatic waitv(input int s, input logic v);
      int k;
      for (k = 0; k < 40; k++) begin
         if ((s == 0 ? freezeOut : debugExceptionPulse) === v) return;
         @(negedge clk);
      end
      err_total++;
      $display("BAD wait%0d exp %b got timeout", s, v);
      print_verdict();
   endtask
   task automatic strap(input logic c, d);
      reset_n = 1'b0;
      i_dsp_tool_model.pins(c, d);
      repeat (16) @(negedge clk);
      reset_n = 1'b1;
      chk("out in reset", 34'h1, debugSerialOut);
      repeat (40) @(negedge clk);
      chk("clock mode", d, configModeStrap);
      chk("entry", c, freezeOut);
   endtask

   initial begin
      {softResetIn, debugModeEn, extIrqLevel, externalIrqEnable, rfiExec} = 5'h00;
      {busSprAttr, busFetch, busRead, busWrite} = 4'h0;
      {causeSetIn, corePc, coreState, busWdata, busAddr} = '0;
      err_total = 0;
      compares = 0;
      strap(1'b0, 1'b0);
      chk("no tick", 34'h1, debugSerialOut);
      $display("done strap");
      te = {7'h53, 2'h0};
      frame(1'b1, 1'b0, 32'h53, 7);
      chk("trap", te, trapEnableCtrl);
      rd(SPR_INSTR_WATCH);
      chk("iwatch", te[8:5], busRdata[3:0]);
      rd(SPR_LS_WATCH2);
      chk("lwatch", te[4:3], busRdata[1:0]);
      frame(1'b1, 1'b1, 32'h3F, 7);
      te[1:0] = 2'h2;
      chk("bp", te, trapEnableCtrl);
      $display("done trap");
      corePc = 32'h0000_1000;
      coreState = 32'h0000_B002;
      debugModeEn = 1'b1;
      pulse(CAUSE_EXT_BIT);
      waitv(0, 1'b1);
      chk("pc", corePc, saveRestorePc);
      chk("state", coreState, saveRestoreState);
      @(negedge clk);
      chk("flush", FLUSH_FROZEN, fetchFlushStatus);
      corePc = 32'h0000_2000;
      pulse(3);
      waitv(1, 1'b1);
      chk("pc kept", 34'h1000, saveRestorePc);
      externalIrqEnable = 1'b1;
      extIrqLevel = 1'b1;
      n = 0;
      repeat (6) begin
         @(negedge clk);
         n += debugExceptionPulse;
      end
      externalIrqEnable = 1'b0;
      chk("level", 34'h1, n >= 4);
      $display("done entry");
      frame(1'b0, 1'b0, 32'h3860_0001, 32);
      fetch(32'h3860_0001);
      frame(1'b0, 1'b1, 32'hCAFE_F00D, 32);
      bus(1'b1, 1'b0, 1'b0, SPR_INSTR_PORT, 32'h0, 20);
      chk("no ack", 34'h0, ack);
      frame(1'b0, 1'b0, 32'h6000_0000, 32);
      chk("seq err", {ST_SEQ_ERR, 1'b1, 31'h7FFF_FFFF}, got);
      fetch(32'h6000_0000);
      frame(1'b0, 1'b1, 32'h1234_5678, 32);
      bus(1'b0, 1'b1, 1'b0, SPR_DATA_PORT, 32'h0, 40);
      chk("dread", {2'h2, 32'h1234_5678}, {ack, 1'b0, busRdata});
      bus(1'b0, 1'b0, 1'b1, SPR_DATA_PORT, 32'hA5C3_0F96, 40);
      chk("dwrite", 34'h1, ack);
      frame(1'b0, 1'b0, 32'h6000_0000, 32);
      chk("out data", {ST_VALID, 32'hA5C3_0F96}, got);
      fetch(32'h6000_0000);
      $display("done port");
      extIrqLevel = 1'b0;
      @(negedge clk);
      rfiExec = 1'b1;
      @(negedge clk);
      rfiExec = 1'b0;
      waitv(0, 1'b0);
      waitv(0, 1'b1);
      rd(SPR_CAUSE);
      chk("cause", 34'h1, busRdata[CAUSE_EXT_BIT]);
      rd(SPR_CAUSE);
      chk("cleared", 34'h0, busRdata);
      @(negedge clk);
      rfiExec = 1'b1;
      @(negedge clk);
      rfiExec = 1'b0;
      repeat (10) @(negedge clk);
      chk("left", 34'h0, {fetchFlushStatus, freezeOut});
      $display("done exit");
      strap(1'b1, 1'b1);
      i_dsp_tool_model.pins(1'b0, 1'b0);
      softResetIn = 1'b1;
      repeat (4) @(negedge clk);
      softResetIn = 1'b0;
      repeat (30) @(negedge clk);
      chk("soft strap", 34'h0, configModeStrap);
      $display("done restrap");
      print_verdict();
   end
endmodule
